// [sif_irq_fifo_ctrl.sv]
// Interrupt pin, flag register and sample-queue source selection for a rate sensor
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module sif_irq_fifo_ctrl #(
    parameter int PULSE_CYCLES = sif_pkg::IRQ_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Sensor samples
    input wire logic sample_tick,
    input wire logic [15:0] temp_sample,
    input wire logic [15:0] x_rate_sample,
    input wire logic [15:0] y_rate_sample,
    input wire logic [15:0] z_rate_sample,
    // Sample queue
    input wire logic fifo_full,
    input wire logic [7:0] fifo_head_data,
    output logic fifo_push,
    output logic [7:0] fifo_push_data,
    output logic fifo_overwrite,
    output logic fifo_pop,
    output logic fifo_read_enable,
    // Pins
    input wire logic frame_sync_pin,
    output logic irq_pin_out,
    output logic irq_pin_oe
);
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_PUSH,
        SEQ_GAP
    } sif_seq_e;

    // Configuration registers
    logic [7:0] src_sel_q;
    logic [7:0] src_sel_d;
    logic [7:0] pin_cfg_q;
    logic [7:0] pin_cfg_d;
    logic [7:0] irq_mask_q;
    logic [7:0] irq_mask_d;
    logic keep_oldest_q;
    logic keep_oldest_d;
    logic rd_enable_q;
    logic rd_enable_d;

    always_comb begin
        src_sel_d = src_sel_q;
        pin_cfg_d = pin_cfg_q;
        irq_mask_d = irq_mask_q;
        keep_oldest_d = keep_oldest_q;
        rd_enable_d = rd_enable_q;
        if (reg_wr) begin
            case (reg_addr)
                sif_pkg::OFS_FIFO_SRC_SEL: src_sel_d = reg_wdata & sif_pkg::SRC_SEL_WMASK;
                sif_pkg::OFS_IRQ_PIN_CFG: pin_cfg_d = reg_wdata & sif_pkg::PIN_CFG_WMASK;
                sif_pkg::OFS_IRQ_SRC_MASK: irq_mask_d = reg_wdata & sif_pkg::IRQ_BITS_MASK;
                sif_pkg::OFS_FIFO_MODE_CFG: keep_oldest_d = reg_wdata[sif_pkg::BIT_FIFO_KEEP_OLDEST];
                sif_pkg::OFS_USER_CTRL: rd_enable_d = reg_wdata[sif_pkg::BIT_FIFO_READ_ENABLE];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_sel_q <= sif_pkg::RST_FIFO_SRC_SEL;
            pin_cfg_q <= sif_pkg::RST_IRQ_PIN_CFG;
            irq_mask_q <= sif_pkg::RST_IRQ_SRC_MASK;
            keep_oldest_q <= sif_pkg::RST_BIT;
            rd_enable_q <= sif_pkg::RST_BIT;
        end else begin
            src_sel_q <= src_sel_d;
            pin_cfg_q <= pin_cfg_d;
            irq_mask_q <= irq_mask_d;
            keep_oldest_q <= keep_oldest_d;
            rd_enable_q <= rd_enable_d;
        end
    end

    // Sensor output registers, refreshed together on every tick
    logic [15:0] temp_q;
    logic [15:0] temp_d;
    logic [15:0] x_q;
    logic [15:0] x_d;
    logic [15:0] y_q;
    logic [15:0] y_d;
    logic [15:0] z_q;
    logic [15:0] z_d;

    always_comb begin
        temp_d = temp_q;
        x_d = x_q;
        y_d = y_q;
        z_d = z_q;
        if (sample_tick) begin
            temp_d = temp_sample;
            x_d = x_rate_sample;
            y_d = y_rate_sample;
            z_d = z_rate_sample;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            temp_q <= sif_pkg::RST_SAMPLE;
            x_q <= sif_pkg::RST_SAMPLE;
            y_q <= sif_pkg::RST_SAMPLE;
            z_q <= sif_pkg::RST_SAMPLE;
        end else begin
            temp_q <= temp_d;
            x_q <= x_d;
            y_q <= y_d;
            z_q <= z_d;
        end
    end

    // Push sequencer: one byte every other cycle so the queue's full flag settles
    logic [63:0] sample_bytes;
    logic [7:0] sel_bytes;
    sif_seq_e seq_q;
    sif_seq_e seq_d;
    logic [7:0] pend_q;
    logic [7:0] pend_d;
    logic push_q;
    logic push_d;
    logic [7:0] push_data_q;
    logic [7:0] push_data_d;
    logic overwrite_q;
    logic overwrite_d;
    logic overflow_evt;
    logic [2:0] pick;

    assign sample_bytes = {temp_q, x_q, y_q, z_q};
    assign sel_bytes = {{2{src_sel_q[sif_pkg::BIT_THERMAL_TO_QUEUE]}},
                        {2{src_sel_q[sif_pkg::BIT_X_RATE_TO_QUEUE]}},
                        {2{src_sel_q[sif_pkg::BIT_Y_RATE_TO_QUEUE]}},
                        {2{src_sel_q[sif_pkg::BIT_Z_RATE_TO_QUEUE]}}};

    always_comb begin
        pick = 3'h0;
        for (int i = 0; i < sif_pkg::SAMPLE_BYTES; i++) begin
            if (pend_q[i]) begin
                pick = 3'(i);
            end
        end
    end

    always_comb begin
        seq_d = seq_q;
        pend_d = pend_q;
        push_d = 1'b0;
        push_data_d = push_data_q;
        overwrite_d = 1'b0;
        overflow_evt = 1'b0;
        case (seq_q)
            SEQ_IDLE: begin
                seq_d = SEQ_IDLE;
            end
            SEQ_PUSH: begin
                push_data_d = sample_bytes[{pick, 3'h0} +: 8];
                pend_d[pick] = 1'b0;
                if (fifo_full) begin
                    overflow_evt = 1'b1;
                    push_d = !keep_oldest_q;
                    overwrite_d = !keep_oldest_q;
                end else begin
                    push_d = 1'b1;
                end
                seq_d = SEQ_GAP;
            end
            SEQ_GAP: begin
                seq_d = (pend_q != 8'h00) ? SEQ_PUSH : SEQ_IDLE;
            end
            default: begin
                seq_d = SEQ_IDLE;
            end
        endcase
        if (sample_tick) begin
            // A new tick restarts the set from the fresh sample
            pend_d = sel_bytes;
            seq_d = (sel_bytes != 8'h00) ? SEQ_GAP : SEQ_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_q <= SEQ_IDLE;
            pend_q <= 8'h00;
            push_q <= 1'b0;
            push_data_q <= 8'h00;
            overwrite_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            pend_q <= pend_d;
            push_q <= push_d;
            push_data_q <= push_data_d;
            overwrite_q <= overwrite_d;
        end
    end

    // Frame-sync pin detection
    logic frame_sync_pin_lvl;
    logic frame_sync_pin_act_q;
    logic frame_sync_pin_act_d;
    logic frame_sync_pin_evt;

    sif_sync u_frame_sync_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(frame_sync_pin),
        .sync_out(frame_sync_pin_lvl)
    );

    always_comb begin
        frame_sync_pin_act_d = frame_sync_pin_lvl ^ pin_cfg_q[sif_pkg::BIT_FRAME_SYNC_POLARITY];
        frame_sync_pin_evt = frame_sync_pin_act_d && !frame_sync_pin_act_q && pin_cfg_q[sif_pkg::BIT_FRAME_SYNC_IRQ_MODE];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_sync_pin_act_q <= 1'b0;
        end else begin
            frame_sync_pin_act_q <= frame_sync_pin_act_d;
        end
    end

    // Flags: a set in the clearing cycle survives
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] set_vec;
    logic flag_clear;

    always_comb begin
        set_vec = 8'h00;
        set_vec[sif_pkg::BIT_OVERFLOW] = overflow_evt;
        set_vec[sif_pkg::BIT_FRAME_SYNC] = frame_sync_pin_evt;
        set_vec[sif_pkg::BIT_DATA_READY] = sample_tick;
        flag_clear = reg_rd && ((reg_addr == sif_pkg::OFS_IRQ_FLAGS)
                     || pin_cfg_q[sif_pkg::BIT_IRQ_ANY_READ_CLEAR]);
        flags_d = (flag_clear ? 8'h00 : flags_q) | set_vec;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= sif_pkg::RST_IRQ_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Interrupt pin
    logic pulse_start;
    logic pulse_busy;
    logic irq_active;
    logic pin_lvl;
    logic irq_out_q;
    logic irq_out_d;
    logic irq_oe_q;
    logic irq_oe_d;

    // Mask gates each source onto the pin
    assign pulse_start = ((set_vec & irq_mask_q) != 8'h00)
                         && !pin_cfg_q[sif_pkg::BIT_IRQ_LATCH];

    sif_pulse_timer #(
        .CYCLES(PULSE_CYCLES)
    ) u_pulse (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(pulse_start),
        .busy(pulse_busy)
    );

    always_comb begin
        irq_active = pin_cfg_q[sif_pkg::BIT_IRQ_LATCH] ? ((flags_q & irq_mask_q) != 8'h00)
                     : pulse_busy;
        pin_lvl = irq_active ^ pin_cfg_q[sif_pkg::BIT_IRQ_ACTIVE_LOW];
        if (pin_cfg_q[sif_pkg::BIT_IRQ_OPEN_DRAIN]) begin
            // Open drain only pulls low; high level comes from the pull-up
            irq_out_d = 1'b0;
            irq_oe_d = !pin_lvl;
        end else begin
            irq_out_d = pin_lvl;
            irq_oe_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_q <= 1'b0;
            irq_oe_q <= 1'b1;
        end else begin
            irq_out_q <= irq_out_d;
            irq_oe_q <= irq_oe_d;
        end
    end

    // Register read-back, valid in the cycle after the strobe only
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic pop_q;
    logic pop_d;

    always_comb begin
        rdata_d = 8'h00;
        pop_d = 1'b0;
        if (reg_rd) begin
            case (reg_addr)
                sif_pkg::OFS_FIFO_SRC_SEL: rdata_d = src_sel_q;
                sif_pkg::OFS_IRQ_PIN_CFG: rdata_d = pin_cfg_q;
                sif_pkg::OFS_IRQ_SRC_MASK: rdata_d = irq_mask_q;
                sif_pkg::OFS_IRQ_FLAGS: rdata_d = flags_q;
                sif_pkg::OFS_THERMAL_HI: rdata_d = temp_q[15:8];
                sif_pkg::OFS_THERMAL_LO: rdata_d = temp_q[7:0];
                sif_pkg::OFS_X_RATE_HI: rdata_d = x_q[15:8];
                sif_pkg::OFS_X_RATE_LO: rdata_d = x_q[7:0];
                sif_pkg::OFS_Y_RATE_HI: rdata_d = y_q[15:8];
                sif_pkg::OFS_Y_RATE_LO: rdata_d = y_q[7:0];
                sif_pkg::OFS_Z_RATE_HI: rdata_d = z_q[15:8];
                sif_pkg::OFS_Z_RATE_LO: rdata_d = z_q[7:0];
                sif_pkg::OFS_FIFO_MODE_CFG: rdata_d = {1'b0, keep_oldest_q, 6'h00};
                sif_pkg::OFS_USER_CTRL: rdata_d = {1'b0, rd_enable_q, 6'h00};
                sif_pkg::OFS_FIFO_DATA: begin
                    if (rd_enable_q) begin
                        rdata_d = fifo_head_data;
                        pop_d = 1'b1;
                    end
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            pop_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            pop_q <= pop_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign fifo_push = push_q;
    assign fifo_push_data = push_data_q;
    assign fifo_overwrite = overwrite_q;
    assign fifo_pop = pop_q;
    assign fifo_read_enable = rd_enable_q;
    assign irq_pin_out = irq_out_q;
    assign irq_pin_oe = irq_oe_q;
endmodule

// [sif_pkg.sv]
// Shared constants for the sensor interrupt and sample-queue source controller
package sif_pkg;
    // Register bus widths
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [6:0] OFS_FIFO_MODE_CFG = 7'h1A;
    localparam logic [6:0] OFS_FIFO_SRC_SEL = 7'h23;
    localparam logic [6:0] OFS_IRQ_PIN_CFG = 7'h37;
    localparam logic [6:0] OFS_IRQ_SRC_MASK = 7'h38;
    localparam logic [6:0] OFS_IRQ_FLAGS = 7'h3A;
    localparam logic [6:0] OFS_THERMAL_HI = 7'h41;
    localparam logic [6:0] OFS_THERMAL_LO = 7'h42;
    localparam logic [6:0] OFS_X_RATE_HI = 7'h43;
    localparam logic [6:0] OFS_X_RATE_LO = 7'h44;
    localparam logic [6:0] OFS_Y_RATE_HI = 7'h45;
    localparam logic [6:0] OFS_Y_RATE_LO = 7'h46;
    localparam logic [6:0] OFS_Z_RATE_HI = 7'h47;
    localparam logic [6:0] OFS_Z_RATE_LO = 7'h48;
    localparam logic [6:0] OFS_USER_CTRL = 7'h6A;
    localparam logic [6:0] OFS_FIFO_DATA = 7'h74;

    // Source select fields
    localparam int BIT_THERMAL_TO_QUEUE = 7;
    localparam int BIT_X_RATE_TO_QUEUE = 6;
    localparam int BIT_Y_RATE_TO_QUEUE = 5;
    localparam int BIT_Z_RATE_TO_QUEUE = 4;
    localparam logic [7:0] SRC_SEL_WMASK = 8'hF0;

    // Pin configuration fields
    localparam int BIT_IRQ_ACTIVE_LOW = 7;
    localparam int BIT_IRQ_OPEN_DRAIN = 6;
    localparam int BIT_IRQ_LATCH = 5;
    localparam int BIT_IRQ_ANY_READ_CLEAR = 4;
    localparam int BIT_FRAME_SYNC_POLARITY = 3;
    localparam int BIT_FRAME_SYNC_IRQ_MODE = 2;
    localparam logic [7:0] PIN_CFG_WMASK = 8'hFC;

    // Mask and flag fields, same positions in both registers
    localparam int BIT_OVERFLOW = 4;
    localparam int BIT_FRAME_SYNC = 3;
    localparam int BIT_DATA_READY = 0;
    localparam logic [7:0] IRQ_BITS_MASK = 8'h19;

    // Queue mode and user control fields
    localparam int BIT_FIFO_KEEP_OLDEST = 6;
    localparam int BIT_FIFO_READ_ENABLE = 6;

    // Reset values
    localparam logic [7:0] RST_FIFO_SRC_SEL = 8'h00;
    localparam logic [7:0] RST_IRQ_PIN_CFG = 8'h00;
    localparam logic [7:0] RST_IRQ_SRC_MASK = 8'h00;
    localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
    localparam logic [15:0] RST_SAMPLE = 16'h0000;
    localparam logic RST_BIT = 1'b0;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int IRQ_PULSE_NS = 50000;
    localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Bytes per sample set: four words of two bytes
    localparam int SAMPLE_BYTES = 8;
endpackage

// [sif_sync.sv]
// Two-flop synchroniser for an asynchronous pin
`timescale 1ns/100ps
module sif_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Pin in, synchronised level out
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

// [sif_pulse_timer.sv]
// Retriggerable pulse timer counting core clock cycles
`timescale 1ns/100ps
module sif_pulse_timer #(
    parameter int CYCLES = 5000
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Start pulse, busy level
    input wire logic start,
    output logic busy
);
    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = LOAD;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy = (cnt_q != '0);
endmodule

// [sif_irq_fifo_ctrl_sva.sv]
// Port-level checker for the interrupt and queue source controller
`timescale 1ns/100ps
module sif_irq_fifo_ctrl_chk #(
    parameter int PULSE_CYCLES = 5000
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [6:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Samples and queue
    input wire logic sample_tick,
    input wire logic fifo_push,
    input wire logic fifo_overwrite,
    input wire logic fifo_pop,
    input wire logic fifo_read_enable,
    // Pin
    input wire logic irq_pin_out,
    input wire logic irq_pin_oe
);
    logic [4:0] age_q;
    logic [4:0] age_d;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Cycles since the last sample tick, saturating
    always_comb begin
        age_d = age_q;
        if (sample_tick) begin
            age_d = 5'h00;
        end else if (age_q != 5'h1F) begin
            age_d = age_q + 5'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            age_q <= 5'h1F;
        end else begin
            age_q <= age_d;
        end
    end

    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    chk_push_gap: assert property (fifo_push |=> !fifo_push)
        else $error("pushes closer than two cycles");
    chk_push_tick: assert property (fifo_push |-> age_q <= 5'h12)
        else $error("push without a recent sample tick");
    chk_ovw_push: assert property (fifo_overwrite |-> fifo_push)
        else $error("overwrite without push");
    chk_pop_cause: assert property (fifo_pop |-> $past(reg_rd) && $past(reg_addr) == sif_pkg::OFS_FIFO_DATA
        && $past(fifo_read_enable)) else $error("pop without an enabled queue read");
    chk_read_lock: assert property ($past(reg_rd) && $past(reg_addr) == sif_pkg::OFS_FIFO_DATA
        && !$past(fifo_read_enable) |-> reg_rdata == 8'h00 && !fifo_pop) else $error("queue read while disabled");
    chk_src_resv: assert property ($past(reg_rd) && $past(reg_addr) == sif_pkg::OFS_FIFO_SRC_SEL
        |-> reg_rdata[3:0] == 4'h0) else $error("source select reserved bits not zero");
    chk_flag_resv: assert property ($past(reg_rd) && $past(reg_addr) == sif_pkg::OFS_IRQ_FLAGS
        |-> (reg_rdata & ~sif_pkg::IRQ_BITS_MASK) == 8'h00) else $error("flag reserved bits not zero");
    chk_od_drive: assert property (!irq_pin_oe |-> !irq_pin_out)
        else $error("pin driven high while released");
endmodule

bind sif_irq_fifo_ctrl sif_irq_fifo_ctrl_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(sample_tick), .fifo_push(fifo_push),
    .fifo_overwrite(fifo_overwrite), .fifo_pop(fifo_pop), .fifo_read_enable(fifo_read_enable),
    .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));

// [sif_queue_model.sv]
// Behavioural sample queue standing at the controller's queue port
`timescale 1ns/100ps
module sif_queue_model #(
    parameter int DEPTH = 6
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Controller side
    input wire logic push,
    input wire logic [7:0] push_data,
    input wire logic overwrite,
    input wire logic pop,
    output logic full,
    output logic [7:0] head
);
    logic [7:0] mem[$];
    logic [7:0] last;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem.delete();
            last = 8'h00;
        end else begin
            if (pop && mem.size() > 0) last = mem.pop_front();
            // Oldest entry gives way before the write
            if (push && overwrite && mem.size() > 0) void'(mem.pop_front());
            if (push && mem.size() < DEPTH) mem.push_back(push_data);
        end
        full <= (mem.size() >= DEPTH);
        // Empty queue shows a changing value, not a stale one
        head <= (mem.size() > 0) ? mem[0] : ~last;
    end
endmodule

// [sif_irq_fifo_ctrl_bench.sv]
// Self-checking bench for the interrupt and queue source controller
`timescale 1ns/100ps
module sif_irq_fifo_ctrl_bench;
    localparam int PCYC = 8;
    localparam int DEPTH = 6;
    logic core_clk, rst_n, reg_wr, reg_rd, sample_tick, frame_sync_pin;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, fifo_head_data, fifo_push_data;
    logic [15:0] temp_sample, x_rate_sample, y_rate_sample, z_rate_sample;
    logic fifo_full, fifo_push, fifo_overwrite, fifo_pop, fifo_read_enable, irq_pin_out, irq_pin_oe;
    logic [7:0] got[$], exq[$], mq[$];
    logic [7:0] flags, src, rv;
    logic [15:0] lt;
    logic [6:0] ra[7] = '{7'h23, 7'h37, 7'h38, 7'h3A, 7'h41, 7'h42, 7'h10};
    logic [6:0] wa[3] = '{7'h23, 7'h37, 7'h38};
    logic [7:0] wm[3] = '{8'hF0, 8'hFC, 8'h19};
    logic [7:0] ca[4] = '{8'h20, 8'hA0, 8'h60, 8'hE0};
    int err_total, checked, keep, hi_cnt;

    sif_irq_fifo_ctrl #(.PULSE_CYCLES(PCYC)) uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(sample_tick),
        .temp_sample(temp_sample), .x_rate_sample(x_rate_sample), .y_rate_sample(y_rate_sample),
        .z_rate_sample(z_rate_sample), .fifo_full(fifo_full), .fifo_head_data(fifo_head_data),
        .fifo_push(fifo_push), .fifo_push_data(fifo_push_data), .fifo_overwrite(fifo_overwrite),
        .fifo_pop(fifo_pop), .fifo_read_enable(fifo_read_enable), .frame_sync_pin(frame_sync_pin),
        .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
    sif_queue_model #(.DEPTH(DEPTH)) queue (.core_clk(core_clk), .rst_n(rst_n), .push(fifo_push),
        .push_data(fifo_push_data), .overwrite(fifo_overwrite), .pop(fifo_pop), .full(fifo_full),
        .head(fifo_head_data));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (fifo_push === 1'b1) got.push_back(fifo_push_data);
        if (irq_pin_out === 1'b1) hi_cnt++;
    end

    task conclude;
        if (err_total == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task cmp(input string what, input logic [7:0] e, input logic [7:0] s);
        checked++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", what, e, s);
            err_total++;
        end
    endtask

    task wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        if (a == sif_pkg::OFS_FIFO_SRC_SEL) src = d & 8'hF0;
    endtask

    task rdc(input logic [6:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        cmp($sformatf("read %h", a), e, reg_rdata);
        if (a == sif_pkg::OFS_IRQ_FLAGS) flags = 8'h00;
    endtask

    // One sample set with random words; model queue and flags follow it
    task tick;
        logic [15:0] w[4];
        logic [7:0] b;
        for (int i = 0; i < 4; i++) w[i] = 16'($urandom);
        @(posedge core_clk);
        temp_sample <= w[0];
        x_rate_sample <= w[1];
        y_rate_sample <= w[2];
        z_rate_sample <= w[3];
        sample_tick <= 1'b1;
        @(posedge core_clk);
        sample_tick <= 1'b0;
        lt = w[0];
        flags[0] = 1'b1;
        for (int i = 0; i < 4; i++) for (int j = 0; j < 2; j++) if (src[7 - i]) begin
            b = (j == 1) ? w[i][7:0] : w[i][15:8];
            if (mq.size() >= DEPTH) flags[4] = 1'b1;
            if (mq.size() < DEPTH || keep == 0) begin
                if (mq.size() >= DEPTH) void'(mq.pop_front());
                mq.push_back(b);
                exq.push_back(b);
            end
        end
        repeat (20) @(posedge core_clk);
        cmp("push count", 8'(exq.size()), 8'(got.size()));
        foreach (exq[i]) cmp("push byte", exq[i], got[i]);
        got.delete();
        exq.delete();
    endtask

    task pin(input logic [7:0] cfg, input logic act);
        logic lv;
        lv = act ^ cfg[7];
        repeat (2) @(posedge core_clk);
        #1;
        cmp("irq pin", cfg[6] ? {7'h00, ~lv} : {6'h00, lv, 1'b1}, {6'h00, irq_pin_out, irq_pin_oe});
    endtask

    initial begin
        #400000;
        err_total++;
        conclude;
    end

    initial begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, sample_tick, frame_sync_pin} = 4'h0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        {temp_sample, x_rate_sample, y_rate_sample, z_rate_sample} = 64'h0;
        {flags, src, keep, err_total, checked, hi_cnt} = '0;
        void'($urandom(28));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (ra[i]) rdc(ra[i], 8'h00);
        for (int k = 0; k < 3; k++) begin
            rv = 8'($urandom);
            wr(wa[k], rv);
            // Random pin setup may arm frame sync on an idle pin; flag survives unless any-read-clear
            if (k == 1 && rv[4:2] == 3'b011) flags[3] = 1'b1;
            rdc(wa[k], rv & wm[k]);
        end
        wr(7'h37, 8'h00);
        wr(7'h38, 8'h00);
        for (int k = 0; k < 16; k++) begin
            wr(7'h23, {k[3:0], 4'($urandom)});
            tick();
            rdc(7'h41, lt[15:8]);
            rdc(7'h42, lt[7:0]);
            rdc(7'h3A, flags);
        end
        rdc(7'h3A, 8'h00);
        rdc(7'h74, 8'h00);
        wr(7'h6A, 8'h40);
        rdc(7'h6A, 8'h40);
        cmp("read enable", 8'h01, {7'h00, fifo_read_enable});
        while (mq.size() > 0) rdc(7'h74, mq.pop_front());
        wr(7'h1A, 8'h40);
        keep = 1;
        wr(7'h23, 8'hF0);
        wr(7'h37, 8'h20);
        wr(7'h38, 8'h10);
        tick();
        pin(8'h20, 1'b1);
        rdc(7'h3A, flags);
        wr(7'h23, 8'h00);
        wr(7'h38, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(7'h37, ca[k]);
            pin(ca[k], 1'b0);
            tick();
            pin(ca[k], 1'b1);
            rdc(7'h3A, 8'h01);
            pin(ca[k], 1'b0);
        end
        wr(7'h38, 8'h00);
        tick();
        pin(8'hE0, 1'b0);
        rdc(7'h3A, 8'h01);
        wr(7'h37, 8'h00);
        wr(7'h38, 8'h01);
        hi_cnt = 0;
        tick();
        cmp("pulse width", 8'(PCYC), 8'(hi_cnt));
        rdc(7'h3A, 8'h01);
        wr(7'h37, 8'h24);
        wr(7'h38, 8'h08);
        @(posedge core_clk);
        frame_sync_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        pin(8'h24, 1'b1);
        rdc(7'h3A, 8'h08);
        @(posedge core_clk);
        frame_sync_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        rdc(7'h3A, 8'h00);
        wr(7'h37, 8'h20);
        frame_sync_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        rdc(7'h3A, 8'h00);
        wr(7'h37, 8'h2C);
        frame_sync_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        rdc(7'h3A, 8'h08);
        wr(7'h37, 8'h30);
        tick();
        rdc(7'h10, 8'h00);
        rdc(7'h3A, 8'h00);
        wr(7'h37, 8'h20);
        tick();
        rdc(7'h23, 8'h00);
        rdc(7'h3A, 8'h01);
        conclude;
    end
endmodule
